// ---- src/dlc_pkg.sv ----
// Constants shared by the disciplined logical clock
package dlc_pkg;
	// Timing
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned TICK_HZ      = 1000;
	localparam int unsigned MS_CYCLES    = CLK_HZ / TICK_HZ;
	localparam int unsigned SEC_CYCLES   = CLK_HZ;
	localparam int unsigned HOLDOVER_SEC = 86400;
	// Widths
	localparam int unsigned ACC_W  = 48;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned FRAC_W = 16;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned AGE_W  = 17;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_OFFSET   = 8'h08;
	localparam logic [7:0] OFF_TICK_INC = 8'h0c;
	localparam logic [7:0] OFF_TIME_LO  = 8'h10;
	localparam logic [7:0] OFF_TIME_HI  = 8'h14;
	localparam logic [7:0] OFF_SLEW     = 8'h18;
	localparam logic [7:0] OFF_DRIFT    = 8'h1c;
	localparam logic [7:0] OFF_COMPL    = 8'h20;
	localparam logic [7:0] OFF_AGE      = 8'h24;
	localparam logic [7:0] OFF_LOOPCFG  = 8'h28;
	localparam logic [7:0] OFF_APERTURE = 8'h2c;
	localparam logic [7:0] OFF_COUNTER  = 8'h30;
	// Control bits
	localparam int unsigned CTRL_INIT   = 0;
	localparam int unsigned CTRL_MAINS  = 1;
	localparam int unsigned CTRL_USECNT = 2;
	localparam int unsigned CTRL_STEP   = 3;
	localparam int unsigned CTRL_PRESET = 4;
	// Status bits
	localparam int unsigned STAT_LEAP    = 0;
	localparam int unsigned STAT_EXPIRED = 2;
	localparam int unsigned STAT_UPDCNT  = 3;
	// Loop configuration fields, four bits each
	localparam int unsigned CFG_UPD = 0;
	localparam int unsigned CFG_ADJ = 4;
	localparam int unsigned CFG_FRQ = 8;
	localparam int unsigned CFG_PHS = 12;
	localparam int unsigned CFG_TRK = 16;
	localparam int unsigned CFG_CMX = 20;
	// Presets and reset values
	localparam logic [31:0] LOOP_XTAL      = 32'h0048_8a28;
	localparam logic [31:0] LOOP_MAINS     = 32'h0000_6a08;
	localparam logic [31:0] APER_XTAL      = 32'h0080_0000;
	localparam logic [31:0] APER_MAINS     = 32'h0200_0000;
	localparam logic [31:0] COMP_MASK      = 32'h0000_017a;
	localparam logic [31:0] TICK_INC_RST   = 32'h0014_0000;
	localparam logic [31:0] MIN_INC_XTAL   = 32'h0002_0000;
	localparam logic [31:0] MIN_INC_MAINS  = 32'h0010_0000;
	localparam int unsigned CNT_OVF_BIT    = 15;
	localparam int unsigned COMP_PRESHIFT  = 8;
	localparam int unsigned COMP_FACT_SH   = 24;
	localparam logic [1:0]  LEAP_UNSYNC    = 2'h3;
	localparam logic [1:0]  LEAP_OK        = 2'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ---- src/dlc_watchdog.sv ----
// Holdover watchdog counting seconds since the last update
`timescale 1ns/1ps
module dlc_watchdog import dlc_pkg::*; #(
	parameter int unsigned LIMIT = HOLDOVER_SEC
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             clear,
	input  wire logic             sec_tick,
	output logic      [AGE_W-1:0] age,
	output logic                  expired
);
	localparam logic [AGE_W-1:0] AGE_SAT = AGE_W'(LIMIT + 1);
	logic [AGE_W-1:0] age_q;
	logic [AGE_W-1:0] age_d;

	always_comb begin
		age_d = age_q;
		if (clear) begin
			age_d = '0;
		end else if (sec_tick && age_q != AGE_SAT) begin
			age_d = age_q + AGE_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			age_q <= '0;
		end else begin
			age_q <= age_d;
		end
	end

	assign age     = age_q;
	assign expired = (age_q > AGE_W'(LIMIT));

	wd_sat_a: assert property (@(posedge aclk) disable iff (!aresetn) age_q <= AGE_SAT)
		else $error("watchdog passed its saturation value");
	wd_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) clear |=> age_q == '0)
		else $error("watchdog not cleared by update");
endmodule

// ---- src/dlc_clock.sv ----
// Disciplined logical clock with AXI4-Lite register access
// Function
// - Startup clears offset, interval, correction, frequency, phase and compliance
// - A time step zeroes only the phase error
// - Frequency gain is ceiling minus factor times compliance, never below one
// - Update loads phase, adds weighted offset to frequency, tracks compliance in crystal mode only
// - Frequency error stays zero for the first two updates
// - Each adjustment adds phase and frequency shares and trims phase error
// - Corrections between updates equal interval over adjustment period
// - Loop parameters configurable with crystal and mains presets
// - 48-bit time accumulator and 32-bit slew register
// - Optional 16-bit buffered tick counter at 1000 Hz
// - Counter overflow bumps the accumulator above the counter bit 15
// - Counter reads are passive; time of day is accumulator plus counter
// - Without counter each periodic tick adds a 32-bit increment
// - Increment clamped on write to at least 2 ms crystal or 16 ms mains
// - Init clears state, sets leap to 11, watchdog counts seconds
// - Each update resets the watchdog
// - Watchdog beyond one day forces leap to 11
// - Small update puts its bits 16-31 sign extended into slew register
// - Adjustment takes slew shifted by phase shift and subtracts it
// - Frequency share is drift shifted by frequency minus update exponent
// - Large update steps the accumulator and zeroes only the slew register
`timescale 1ns/1ps
module dlc_clock import dlc_pkg::*; #(
	parameter int unsigned MS_CYC   = MS_CYCLES,
	parameter int unsigned SEC_CYC  = SEC_CYCLES,
	parameter int unsigned HOLD_SEC = HOLDOVER_SEC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [31:0]       s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              tick_in,
	output logic      [1:0]        leap_ind,
	output logic      [ACC_W-1:0]  time_of_day
);
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [ACC_W-1:0] sx48(input logic [31:0] v);
		return {{(ACC_W-32){v[31]}}, v};
	endfunction

	function automatic logic [31:0] mag32(input logic [31:0] v);
		return v[31] ? 32'(-v) : v;
	endfunction

	function automatic logic [4:0] log2f(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) r = 5'(i);
		end
		return r;
	endfunction

	// Bus state
	logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]        wstrb_q, wstrb_d;
	logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic [15:0]       snap_hi_q, snap_hi_d;
	// Loop state
	logic [ACC_W-1:0]  acc_q, acc_d, tod_q, tod_d;
	logic signed [31:0] slew_q, slew_d, drift_q, drift_d, comp_q, comp_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [31:0]       ms_div_q, ms_div_d, sec_div_q, sec_div_d;
	logic [15:0]       adj_cnt_q, adj_cnt_d;
	logic [1:0]        upd_cnt_q, upd_cnt_d, leap_q, leap_d;
	logic              mains_q, mains_d, usecnt_q, usecnt_d, stepreq_q, stepreq_d;
	logic [31:0]       loopcfg_q, loopcfg_d, aper_q, aper_d, tickinc_q, tickinc_d;
	logic [31:0]       lastoff_q, lastoff_d;
	logic              tick_s1_q, tick_s2_q, tick_s3_q;
	// Internal signals
	logic              wr_fire, ar_fire, wr_ctrl, upd, init, step, adjust;
	logic              ms_tick, sec_tick, tick_edge, ovf, expired;
	logic [AGE_W-1:0]  age;
	logic [3:0]        upd_exp, adj_exp, frq_sh, phs_sh, trk_sh, cmx_exp;
	logic signed [31:0] offs, phase_c, freq_c, gain_a;
	logic [4:0]        gshift;
	logic [ACC_W-1:0]  inc;
	logic signed [39:0] comp_diff;
	logic [31:0]       min_inc;

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign leap_ind      = leap_q;
	assign time_of_day   = tod_q;

	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign ar_fire = s_axi_arvalid && !rvalid_q;
	assign wr_ctrl = wr_fire && awaddr_q == OFF_CTRL;
	assign init    = wr_ctrl && wdata_q[CTRL_INIT];
	assign upd     = wr_fire && awaddr_q == OFF_OFFSET && !init;
	assign offs    = wdata_q;
	assign step    = upd && (stepreq_q || mag32(offs) >= aper_q);

	assign upd_exp = loopcfg_q[CFG_UPD +: 4];
	assign adj_exp = loopcfg_q[CFG_ADJ +: 4];
	assign frq_sh  = loopcfg_q[CFG_FRQ +: 4];
	assign phs_sh  = loopcfg_q[CFG_PHS +: 4];
	assign trk_sh  = loopcfg_q[CFG_TRK +: 4];
	assign cmx_exp = loopcfg_q[CFG_CMX +: 4];

	assign ms_tick   = ms_div_q == 32'(MS_CYC - 1);
	assign sec_tick  = sec_div_q == 32'(SEC_CYC - 1);
	assign tick_edge = tick_s2_q && !tick_s3_q;
	assign ovf       = usecnt_q && ms_tick && cnt_q == '1;
	assign adjust    = sec_tick && adj_cnt_q == 16'((17'h1 << adj_exp) - 17'h1);

	// Frequency gain, clamped at one
	always_comb begin
		gain_a = (32'sh1 <<< cmx_exp) - $signed(mag32(comp_q) >> COMP_FACT_SH);
		if (gain_a < 32'sh1) gain_a = 32'sh1;
		gshift = log2f(gain_a);
	end

	assign phase_c   = slew_q >>> phs_sh;
	assign freq_c    = drift_q >>> ((frq_sh > upd_exp) ? (frq_sh - upd_exp) : 4'h0);
	assign comp_diff = $signed({offs, 8'h00}) - 40'(comp_q);
	assign min_inc   = mains_q ? MIN_INC_MAINS : MIN_INC_XTAL;

	dlc_watchdog #(.LIMIT(HOLD_SEC)) u_wdog (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.clear    (upd || init),
		.sec_tick (sec_tick),
		.age      (age),
		.expired  (expired)
	);

	// Bus next state
	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d  = w_hold_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q && !s_axi_bready;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q && !s_axi_rready;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		snap_hi_d = snap_hi_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_d = 1'b1;
			awaddr_d  = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_hold_d = 1'b0;
			w_hold_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = (awaddr_q > OFF_APERTURE || awaddr_q == OFF_STATUS) ? RESP_SLVERR
				: RESP_OKAY;
		end
		if (ar_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				OFF_CTRL:     rdata_d = 32'({stepreq_q, usecnt_q, mains_q, 1'b0});
				OFF_STATUS:   rdata_d = 32'({upd_cnt_q, expired, leap_q});
				OFF_OFFSET:   rdata_d = lastoff_q;
				OFF_TICK_INC: rdata_d = tickinc_q;
				OFF_TIME_LO: begin
					rdata_d   = tod_q[31:0];
					snap_hi_d = tod_q[47:32];
				end
				OFF_TIME_HI:  rdata_d = {16'h0000, snap_hi_q};
				OFF_SLEW:     rdata_d = slew_q;
				OFF_DRIFT:    rdata_d = drift_q;
				OFF_COMPL:    rdata_d = comp_q;
				OFF_AGE:      rdata_d = 32'(age);
				OFF_LOOPCFG:  rdata_d = loopcfg_q;
				OFF_APERTURE: rdata_d = aper_q;
				OFF_COUNTER:  rdata_d = {16'h0000, cnt_q};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
			snap_hi_q <= 16'h0000;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			snap_hi_q <= snap_hi_d;
		end
	end

	// Loop next state
	always_comb begin
		ms_div_d  = ms_tick ? 32'h0000_0000 : ms_div_q + 32'h1;
		sec_div_d = sec_tick ? 32'h0000_0000 : sec_div_q + 32'h1;
		adj_cnt_d = adjust ? 16'h0000 : (sec_tick ? adj_cnt_q + 16'h1 : adj_cnt_q);
		cnt_d     = (usecnt_q && ms_tick) ? cnt_q + CNT_W'(1) : cnt_q;
		slew_d    = slew_q;
		drift_d   = drift_q;
		comp_d    = comp_q;
		upd_cnt_d = upd_cnt_q;
		leap_d    = expired ? LEAP_UNSYNC : leap_q;
		lastoff_d = lastoff_q;
		mains_d   = mains_q;
		usecnt_d  = usecnt_q;
		stepreq_d = stepreq_q;
		loopcfg_d = loopcfg_q;
		aper_d    = aper_q;
		tickinc_d = tickinc_q;
		inc       = '0;
		if (ovf) inc = inc + (ACC_W'(1) << (FRAC_W + CNT_OVF_BIT + 1));
		if (!usecnt_q && tick_edge) inc = inc + ACC_W'(tickinc_q);
		if (adjust) begin
			inc    = inc + sx48(phase_c) + sx48(freq_c);
			slew_d = slew_q - phase_c;
		end
		acc_d = acc_q + inc;
		tod_d = usecnt_q ? acc_q + {{(ACC_W-CNT_W-FRAC_W){1'b0}}, cnt_q, 16'h0000} : acc_q;
		if (upd) begin
			lastoff_d = offs;
			leap_d    = LEAP_OK;
			stepreq_d = 1'b0;
			if (step) begin
				acc_d  = acc_q + inc + sx48(offs);
				slew_d = 32'sh0;
			end else begin
				slew_d = {{16{offs[31]}}, offs[31:16]};
				if (upd_cnt_q == 2'h2) drift_d = drift_q + (offs >>> (gshift + 5'(upd_exp)));
				if (!mains_q) comp_d = comp_q + 32'(comp_diff >>> trk_sh);
				if (upd_cnt_q != 2'h2) upd_cnt_d = upd_cnt_q + 2'h1;
			end
		end
		if (wr_ctrl) begin
			mains_d   = wdata_q[CTRL_MAINS];
			usecnt_d  = wdata_q[CTRL_USECNT];
			stepreq_d = wdata_q[CTRL_STEP];
			if (wdata_q[CTRL_PRESET]) begin
				loopcfg_d = wdata_q[CTRL_MAINS] ? LOOP_MAINS : LOOP_XTAL;
				aper_d    = wdata_q[CTRL_MAINS] ? APER_MAINS : APER_XTAL;
			end
		end
		if (wr_fire && awaddr_q == OFF_LOOPCFG) loopcfg_d = merge(loopcfg_q, wdata_q, wstrb_q);
		if (wr_fire && awaddr_q == OFF_APERTURE) aper_d = merge(aper_q, wdata_q, wstrb_q);
		if (wr_fire && awaddr_q == OFF_TICK_INC) begin
			tickinc_d = merge(tickinc_q, wdata_q, wstrb_q);
			if (tickinc_d < min_inc) tickinc_d = min_inc;
		end
		if (init) begin
			acc_d     = '0;
			tod_d     = '0;
			slew_d    = 32'sh0;
			drift_d   = 32'sh0;
			comp_d    = 32'sh0;
			cnt_d     = '0;
			upd_cnt_d = 2'h0;
			adj_cnt_d = 16'h0000;
			sec_div_d = 32'h0000_0000;
			ms_div_d  = 32'h0000_0000;
			lastoff_d = 32'h0000_0000;
			leap_d    = LEAP_UNSYNC;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q     <= '0;
			tod_q     <= '0;
			slew_q    <= 32'sh0;
			drift_q   <= 32'sh0;
			comp_q    <= 32'sh0;
			cnt_q     <= '0;
			ms_div_q  <= 32'h0000_0000;
			sec_div_q <= 32'h0000_0000;
			adj_cnt_q <= 16'h0000;
			upd_cnt_q <= 2'h0;
			leap_q    <= LEAP_UNSYNC;
			lastoff_q <= 32'h0000_0000;
			mains_q   <= 1'b0;
			usecnt_q  <= 1'b0;
			stepreq_q <= 1'b0;
			loopcfg_q <= LOOP_XTAL;
			aper_q    <= APER_XTAL;
			tickinc_q <= TICK_INC_RST;
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_s3_q <= 1'b0;
		end else begin
			acc_q     <= acc_d;
			tod_q     <= tod_d;
			slew_q    <= slew_d;
			drift_q   <= drift_d;
			comp_q    <= comp_d;
			cnt_q     <= cnt_d;
			ms_div_q  <= ms_div_d;
			sec_div_q <= sec_div_d;
			adj_cnt_q <= adj_cnt_d;
			upd_cnt_q <= upd_cnt_d;
			leap_q    <= leap_d;
			lastoff_q <= lastoff_d;
			mains_q   <= mains_d;
			usecnt_q  <= usecnt_d;
			stepreq_q <= stepreq_d;
			loopcfg_q <= loopcfg_d;
			aper_q    <= aper_d;
			tickinc_q <= tickinc_d;
			tick_s1_q <= tick_in;
			tick_s2_q <= tick_s1_q;
			tick_s3_q <= tick_s2_q;
		end
	end

	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence small_upd_s;
		upd && !step;
	endsequence

	init_clear_a: assert property (init |=> slew_q == 0 && drift_q == 0 && comp_q == 0
		&& upd_cnt_q == 0 && acc_q == 0) else $error("init did not clear loop state");
	step_keep_a: assert property (step |=> slew_q == 0 && drift_q == $past(drift_q)
		&& comp_q == $past(comp_q)) else $error("step disturbed more than phase");
	gain_floor_a: assert property (gain_a >= 32'sh1 && gain_a <= (32'sh1 <<< cmx_exp))
		else $error("frequency gain below one");
	slew_load_a: assert property (small_upd_s |=> slew_q == $signed({{16{$past(offs[31])}},
		$past(offs[31:16])})) else $error("slew not loaded from update");
	drift_hold_a: assert property (small_upd_s and upd_cnt_q != 2'h2
		|=> drift_q == $past(drift_q)) else $error("drift moved during first updates");
	adjust_slew_a: assert property (adjust && !upd && !init |=>
		slew_q == $past(slew_q) - $past(phase_c)) else $error("slew not trimmed on adjust");
	leap_init_a: assert property (init |=> leap_q == LEAP_UNSYNC)
		else $error("leap not unsynchronized after init");
	expire_leap_a: assert property (expired && !upd && !init |=> leap_q == LEAP_UNSYNC)
		else $error("leap not forced on holdover expiry");
	min_inc_a: assert property (tickinc_q >= MIN_INC_XTAL)
		else $error("tick increment below floor");
endmodule

// ---- verification/dlc_tick_src.sv ----
// Periodic tick source standing in for the event line
`timescale 1ns/1ps
module dlc_tick_src #(
	parameter int unsigned HI = 4
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       start,
	input  wire logic [3:0] count,
	output logic            tick,
	output logic            busy
);
	logic [3:0] left_q, left_d;
	logic [3:0] ph_q, ph_d;
	always_comb begin
		left_d = left_q;
		ph_d = ph_q;
		if (start && left_q == 4'h0) begin
			left_d = count;
			ph_d = 4'h0;
		end else if (left_q != 4'h0) begin
			ph_d = ph_q + 4'h1;
			if (ph_q == 4'(2 * HI - 1)) begin
				ph_d = 4'h0;
				left_d = left_q - 4'h1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		left_q <= aresetn ? left_d : 4'h0;
		ph_q <= aresetn ? ph_d : 4'h0;
	end
	// Pulse high for HI cycles, low between pulses and when idle
	assign busy = left_q != 4'h0;
	assign tick = busy && ph_q < 4'(HI);
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the disciplined logical clock
`timescale 1ns/1ps
module tb_top import dlc_pkg::*;;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} dlc_row_t;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = 32'h0;
	logic [3:0]        wstrb = 4'hf;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, leap_ind, resp;
	logic [31:0]       rdata, rd;
	logic [ACC_W-1:0]  time_of_day;
	logic              tick, busy, start = 1'b0;
	logic              aw_t, w_t, ar_t, b_t, r_t;
	logic [1:0]        bresp_q, rresp_q;
	logic [31:0]       rdata_q;
	int                n_fail = 0, num_checks = 0;
	localparam logic [47:0] INC = 48'h0014_0000;
	dlc_row_t rows [7] = '{
		'{OFF_LOOPCFG, LOOP_XTAL, RESP_OKAY}, '{OFF_APERTURE, APER_XTAL, RESP_OKAY},
		'{OFF_TICK_INC, TICK_INC_RST, RESP_OKAY}, '{OFF_SLEW, 32'h0, RESP_OKAY},
		'{OFF_DRIFT, 32'h0, RESP_OKAY}, '{OFF_COMPL, 32'h0, RESP_OKAY},
		'{8'h3c, 32'h0, RESP_SLVERR}};
	always #10 aclk = ~aclk;
	dlc_clock #(.MS_CYC(4), .SEC_CYC(20), .HOLD_SEC(3)) DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tick_in(tick), .leap_ind(leap_ind), .time_of_day(time_of_day));
	dlc_tick_src #(.HI(4)) partner (
		.aclk(aclk), .aresetn(aresetn), .start(start), .count(4'h5),
		.tick(tick), .busy(busy));
	// Handshakes and answers as seen at the rising edge
	always @(posedge aclk) begin
		aw_t <= awvalid && awready;
		w_t <= wvalid && wready;
		ar_t <= arvalid && arready;
		b_t <= bvalid && bready;
		r_t <= rvalid && rready;
		bresp_q <= bresp;
		rresp_q <= rresp;
		rdata_q <= rdata;
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		step(1);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			step(1);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			n++;
		end while (!b_t && n < 100);
		bready <= 1'b0;
		r = bresp_q;
		if (!b_t) chk(48'h1, 48'h0);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		step(1);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			step(1);
			if (ar_t) arvalid <= 1'b0;
			n++;
		end while (!r_t && n < 100);
		rready <= 1'b0;
		d = rdata_q;
		r = rresp_q;
		if (!r_t) chk(48'h1, 48'h0);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		results();
	end
	initial begin
		step(16);
		aresetn <= 1'b1;
		step(1);
		chk(48'(leap_ind), 48'(LEAP_UNSYNC));
		chk(time_of_day, 48'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			axr(rows[i].a, rd, resp);
			chk({rd, 14'h0, resp}, {rows[i].d, 14'h0, rows[i].r});
		end
		$display("test register table done");
		axw(OFF_TICK_INC, 32'h0000_0001, resp);
		axr(OFF_TICK_INC, rd, resp);
		chk(48'(rd), 48'(MIN_INC_XTAL));
		axw(OFF_TICK_INC, TICK_INC_RST, resp);
		axw(OFF_STATUS, 32'h0, resp);
		chk(48'(resp), 48'(RESP_SLVERR));
		$display("test increment clamp done");
		start <= 1'b1;
		step(1);
		start <= 1'b0;
		while (busy) step(1);
		step(10);
		chk(time_of_day, 48'd5 * INC);
		axr(OFF_TIME_LO, rd, resp);
		chk(48'(rd), 48'd5 * INC);
		$display("test periodic ticks done");
		axw(OFF_OFFSET, 32'h0003_8000, resp);
		step(2);
		chk(48'(leap_ind), 48'(LEAP_OK));
		axr(OFF_SLEW, rd, resp);
		chk(48'(rd), 48'h3);
		axw(OFF_OFFSET, 32'hfffd_0000, resp);
		axr(OFF_SLEW, rd, resp);
		chk(48'(rd), 48'hffff_fffd);
		axr(OFF_DRIFT, rd, resp);
		chk(48'(rd), 48'h0);
		$display("test small update done");
		axw(OFF_OFFSET, 32'h0100_0000, resp);
		step(4);
		chk(time_of_day, 48'd5 * INC + 48'h0100_0000);
		axr(OFF_SLEW, rd, resp);
		chk(48'(rd), 48'h0);
		$display("test step update done");
		step(130);
		chk(48'(leap_ind), 48'(LEAP_UNSYNC));
		axr(OFF_AGE, rd, resp);
		chk(48'(rd), 48'd4);
		axr(OFF_STATUS, rd, resp);
		chk(48'(rd[STAT_EXPIRED]), 48'h1);
		axw(OFF_OFFSET, 32'h0001_0000, resp);
		step(2);
		chk(48'(leap_ind), 48'(LEAP_OK));
		$display("test holdover done");
		axw(OFF_CTRL, 32'h0000_0001, resp);
		step(3);
		chk(48'(leap_ind), 48'(LEAP_UNSYNC));
		chk(time_of_day, 48'h0);
		axr(OFF_SLEW, rd, resp);
		chk(48'(rd), 48'h0);
		axr(OFF_COMPL, rd, resp);
		chk(48'(rd), 48'h0);
		$display("test init done");
		axw(OFF_CTRL, 32'h0000_0016, resp);
		axr(OFF_LOOPCFG, rd, resp);
		chk(48'(rd), 48'(LOOP_MAINS));
		step(5);
		axw(OFF_OFFSET, 32'h0100_0000, resp);
		step(20);
		chk(time_of_day, 48'h0008_0004);
		axr(OFF_SLEW, rd, resp);
		chk(48'(rd), 48'h0000_00fc);
		$display("test mains adjust done");
		results();
	end
endmodule
